//--- bench/ext_pwm_source.sv
// External PWM source model that drives the keypad PWM pin.
module ext_pwm_source (
  input  wire logic clk_i,
  input  wire logic level_i,
  output logic      pwm_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // A high level asks for the selected outputs to be on.
  always_ff @(posedge clk_i) begin
    pwm_o <= level_i;
  end
endmodule

//--- bench/keypad_led_output_control_tb_top.sv
// Self-checking testbench for the keypad LED output control.
module keypad_led_output_control_tb_top;
  import keypad_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, rst, reg_write, pin_level, pwm_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       led1, led2, led3, switch_mode;
  logic [1:0] code1, code2, code3;
  logic [9:0] highs, rises;
  int         err_count, num_checks;

  ////////////////////////////////////////////////////////////////////////////
  keypad_led_output_control uut (.clk_i(clk), .rst_i(rst), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .pwm_pin_i(pwm_pin), .reg_rdata_o(reg_rdata), .led_out_1_o(led1),
    .led_out_2_o(led2), .led_out_3_o(led3), .switch_mode_o(switch_mode), .out1_current_code_o(code1),
    .out2_current_code_o(code2), .out3_current_code_o(code3));
  ext_pwm_source src (.clk_i(clk), .level_i(pin_level), .pwm_o(pwm_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    pin_level <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic count(input int n);
    logic prev;
    highs = '0;
    rises = '0;
    prev  = led1;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (led1 === 1'b1) highs++;
      if (led1 === 1'b1 && prev !== 1'b1) rises++;
      prev = led1;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk("leds reset", {7'h00, led1, led2, led3}, 10'h000);
    wr(8'h05, 8'h3f);
    rd(CTRL_ADDR);
    chk("ctrl reset", {2'b00, d}, 10'h008);
    chk("mode reset", {9'h000, switch_mode}, 10'h001);
    rd(CURRENT_ADDR);
    chk("current reset", {2'b00, d}, 10'h000);
    rd(8'h05);
    chk("unmapped read", {2'b00, d}, 10'h000);
    $display("test reset done");
  endtask

  task automatic test_direct();
    wr(CTRL_ADDR, 8'h25);
    chk("direct leds", {7'h00, led1, led2, led3}, 10'h005);
    wr(BRIGHT_ADDR, 8'h7f);
    chk("bright ignored", {7'h00, led1, led2, led3}, 10'h005);
    wr(CTRL_ADDR, 8'h07);
    chk("keypad off", {7'h00, led1, led2, led3}, 10'h000);
    $display("test direct done");
  endtask

  task automatic test_current();
    wr(CURRENT_ADDR, 8'h2d);
    chk("codes", {4'h0, code1, code2, code3}, 10'h02d);
    rd(CURRENT_ADDR);
    chk("current read", {2'b00, d}, 10'h02d);
    wr(CTRL_ADDR, 8'h28);
    chk("switch mode", {9'h000, switch_mode}, 10'h001);
    wr(CTRL_ADDR, 8'h20);
    chk("cc mode", {9'h000, switch_mode}, 10'h000);
    $display("test current done");
  endtask

  task automatic test_ext();
    wr(GPIO_ADDR, 8'h10);
    wr(EXTSEL_ADDR, 8'h05);
    wr(CTRL_ADDR, 8'h23);
    pin(1'b0);
    chk("ext low", {7'h00, led1, led2, led3}, 10'h002);
    pin(1'b1);
    chk("ext high", {7'h00, led1, led2, led3}, 10'h006);
    wr(EXTSEL_ADDR, 8'h07);
    pin(1'b0);
    chk("ext all low", {7'h00, led1, led2, led3}, 10'h000);
    wr(GPIO_ADDR, 8'h00);
    pin(1'b0);
    chk("pin disabled", {7'h00, led1, led2, led3}, 10'h006);
    wr(GPIO_ADDR, 8'h10);
    pin(1'b1);
    wr(CTRL_ADDR, 8'h26);
    chk("ext needs enable", {7'h00, led1, led2, led3}, 10'h003);
    wr(CTRL_ADDR, 8'h03);
    chk("ext no keypad", {7'h00, led1, led2, led3}, 10'h000);
    $display("test ext done");
  endtask

  task automatic test_int();
    wr(EXTSEL_ADDR, 8'h00);
    wr(GPIO_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h31);
    for (int c = 0; c < 8; c++) begin
      wr(BRIGHT_ADDR, 8'(c << BRIGHT_CODE_LSB));
      count(2 * PWM_PERIOD_CYCLES);
      chk("duty", highs, (c == 0) ? 10'h000 : 10'(2 * (PWM_PERIOD_CYCLES >> (7 - c))));
      chk("periods", rises, (c > 0 && c < 7) ? 10'h002 : 10'h000);
    end
    $display("test int done");
  endtask

  task automatic test_gate();
    wr(GPIO_ADDR, 8'h10);
    wr(EXTSEL_ADDR, 8'h05);
    wr(CTRL_ADDR, 8'h35);
    wr(BRIGHT_ADDR, 8'h0c);
    pin(1'b0);
    count(PWM_PERIOD_CYCLES);
    chk("gate low", highs, 10'h000);
    pin(1'b1);
    count(PWM_PERIOD_CYCLES);
    chk("gate high", highs, 10'(PWM_PERIOD_CYCLES >> 1));
    $display("test gate done");
  endtask

  task automatic test_rerun();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    $display("test rerun done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst       = 1'b1;
    reg_write = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    pin_level = 1'b0;
    err_count  = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_direct();
    test_current();
    test_ext();
    test_int();
    test_gate();
    test_rerun();
    summarize();
  end

  initial begin
    #(30_000 * 100);
    err_count++;
    summarize();
  end
endmodule

//--- logic/keypad_led_output_control.sv
// Keypad LED output control: registers, mode selection and output gating.
// Behaviour
// - Direct mode: output follows its enable bit.
// - Brightness register ignored in direct mode.
// - Mode bit: high switch, low current; reset switch.
// - Current register 02H holds three two-bit codes.
// - Code scales sink current quarter to full.
// - External PWM needs pin enable and keypad enable.
// - External PWM drives only enabled, selected outputs.
// - External PWM input is active high.
// - Internal PWM off: selected outputs follow input.
// - Internal PWM on: gated by external input.
// - Internal PWM runs near 20 kHz.
// - Enable bits stay individual enables under external PWM.
// - Mode, enables, keypad enable live in 00H.
// - Three-bit logarithmic duty code, 1/64 doubling.
module keypad_led_output_control
  import keypad_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       pwm_pin_i,
  output logic [7:0]      reg_rdata_o,
  output logic            led_out_1_o,
  output logic            led_out_2_o,
  output logic            led_out_3_o,
  output logic            switch_mode_o,
  output logic [1:0]      out1_current_code_o,
  output logic [1:0]      out2_current_code_o,
  output logic [1:0]      out3_current_code_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  ctrl_type   ctrl;
  ctrl_type   next_ctrl;
  bright_type bright;
  bright_type next_bright;
  logic [5:0] current_codes;
  logic [5:0] next_current_codes;
  logic [4:0] gpio_ctrl;
  logic [4:0] next_gpio_ctrl;
  logic [2:0] ext_select;
  logic [2:0] next_ext_select;
  logic [7:0] next_rdata;

  always_comb begin
    next_ctrl          = ctrl;
    next_bright        = bright;
    next_current_codes = current_codes;
    next_gpio_ctrl     = gpio_ctrl;
    next_ext_select    = ext_select;
    if (reg_write_i) begin
      case (reg_addr_i)
        CTRL_ADDR:    next_ctrl = ctrl_type'(reg_wdata_i[5:0]);
        BRIGHT_ADDR:  next_bright = bright_type'(reg_wdata_i[6:0]);
        CURRENT_ADDR: next_current_codes = reg_wdata_i[5:0];
        GPIO_ADDR:    next_gpio_ctrl = reg_wdata_i[4:0];
        EXTSEL_ADDR:  next_ext_select = reg_wdata_i[2:0];
        default:      next_ctrl = ctrl;
      endcase
    end
    case (reg_addr_i)
      CTRL_ADDR:    next_rdata = {2'h0, ctrl};
      BRIGHT_ADDR:  next_rdata = {1'h0, bright};
      CURRENT_ADDR: next_rdata = {2'h0, current_codes};
      GPIO_ADDR:    next_rdata = {3'h0, gpio_ctrl};
      EXTSEL_ADDR:  next_rdata = {5'h00, ext_select};
      default:      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl          <= ctrl_type'(CTRL_RESET);
      bright        <= bright_type'(BRIGHT_RESET);
      current_codes <= CURRENT_RESET;
      gpio_ctrl     <= GPIO_RESET;
      ext_select    <= EXTSEL_RESET;
      reg_rdata_o   <= 8'h00;
    end else begin
      ctrl          <= next_ctrl;
      bright        <= next_bright;
      current_codes <= next_current_codes;
      gpio_ctrl     <= next_gpio_ctrl;
      ext_select    <= next_ext_select;
      reg_rdata_o   <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External PWM pin synchroniser and internal PWM.

  logic pin_meta;
  logic ext_pwm;
  logic int_pwm;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      ext_pwm  <= 1'b0;
    end else begin
      pin_meta <= pwm_pin_i;
      ext_pwm  <= pin_meta;
    end
  end

  keypad_pwm pwm_gen (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .bright_i (bright.brightness),
    .pwm_o    (int_pwm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output gating.

  logic [2:0] on_bits;
  logic [2:0] next_led;
  logic       ext_active;

  assign on_bits    = {ctrl.out3_on, ctrl.out2_on, ctrl.out1_on};
  assign ext_active = ctrl.keypad_enable & gpio_ctrl[PWM_PIN_EN_BIT];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!ctrl.keypad_enable) begin
        next_led[i] = 1'b0;
      end else if (ext_active && ext_select[i]) begin
        // The enable bit remains the gate; the pin is active high.
        if (ctrl.internal_pwm_select) begin
          next_led[i] = on_bits[i] & ext_pwm & int_pwm;
        end else begin
          next_led[i] = on_bits[i] & ext_pwm;
        end
      end else if (ctrl.internal_pwm_select) begin
        next_led[i] = on_bits[i] & int_pwm;
      end else begin
        next_led[i] = on_bits[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_out_1_o         <= 1'b0;
      led_out_2_o         <= 1'b0;
      led_out_3_o         <= 1'b0;
      switch_mode_o       <= CTRL_RESET[3];
      out1_current_code_o <= 2'h0;
      out2_current_code_o <= 2'h0;
      out3_current_code_o <= 2'h0;
    end else begin
      led_out_1_o         <= next_led[0];
      led_out_2_o         <= next_led[1];
      led_out_3_o         <= next_led[2];
      switch_mode_o       <= ctrl.output_mode_select;
      out1_current_code_o <= current_codes[OUT1_CODE_LSB +: 2];
      out2_current_code_o <= current_codes[OUT2_CODE_LSB +: 2];
      out3_current_code_o <= current_codes[OUT3_CODE_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_disabled_off;
    !ctrl.keypad_enable |=> {led_out_3_o, led_out_2_o, led_out_1_o} == 3'h0;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("Output on while disabled.");

  property p_direct_follow;
    ctrl.keypad_enable && !ctrl.internal_pwm_select && !gpio_ctrl[PWM_PIN_EN_BIT]
      |=> {led_out_3_o, led_out_2_o, led_out_1_o} == $past(on_bits);
  endproperty
  a_direct_follow: assert property (p_direct_follow) else $error("Direct output mismatch.");

  property p_direct_ignores_bright;
    ctrl.keypad_enable && !ctrl.internal_pwm_select && !gpio_ctrl[PWM_PIN_EN_BIT] && ctrl.out1_on
      ##1 ctrl.keypad_enable && !ctrl.internal_pwm_select && !gpio_ctrl[PWM_PIN_EN_BIT] && ctrl.out1_on
      |=> led_out_1_o [*1];
  endproperty
  a_direct_ignores_bright: assert property (p_direct_ignores_bright) else $error("Direct output dimmed.");

  property p_mode_reflect;
    1'b1 |=> switch_mode_o == $past(ctrl.output_mode_select);
  endproperty
  a_mode_reflect: assert property (p_mode_reflect) else $error("Mode output wrong.");

  property p_code_out1;
    ##1 out1_current_code_o == $past(current_codes[5:4]);
  endproperty
  a_code_out1: assert property (p_code_out1) else $error("Output one code wrong.");

  property p_ext_direct;
    ext_active && ext_select[0] && !ctrl.internal_pwm_select |=> led_out_1_o == $past(on_bits[0] & ext_pwm);
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("External PWM not followed.");

  property p_ext_low_off;
    ext_active && ext_select[1] && !ext_pwm |=> !led_out_2_o;
  endproperty
  a_ext_low_off: assert property (p_ext_low_off) else $error("Output on with pin low.");

  property p_ext_gated;
    ext_active && ext_select[2] && ctrl.internal_pwm_select
      |=> led_out_3_o == $past(on_bits[2] & ext_pwm & int_pwm);
  endproperty
  a_ext_gated: assert property (p_ext_gated) else $error("Gated PWM wrong.");

  property p_ext_needs_enable;
    ext_active && ext_select[0] && !ctrl.out1_on |=> !led_out_1_o;
  endproperty
  a_ext_needs_enable: assert property (p_ext_needs_enable) else $error("Unenabled output driven.");

  c_direct_on: cover property (ctrl.keypad_enable && !ctrl.internal_pwm_select ##1 led_out_1_o);
  c_ext_direct: cover property (ext_active && ext_select[0] && ext_pwm ##1 led_out_1_o);
  c_ext_gated: cover property (ext_active && ext_select[2] && ctrl.internal_pwm_select ##1 led_out_3_o);
  c_current_mode: cover property (!switch_mode_o && out2_current_code_o == 2'h3);

endmodule

//--- logic/keypad_pkg.sv
// Shared constants and types for the keypad LED output control.
package keypad_pkg;

  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] BRIGHT_ADDR  = 8'h01;
  localparam logic [7:0] CURRENT_ADDR = 8'h02;
  localparam logic [7:0] GPIO_ADDR    = 8'h06;
  localparam logic [7:0] EXTSEL_ADDR  = 8'h08;

  localparam int PWM_PIN_EN_BIT  = 4;
  localparam int OUT1_CODE_LSB   = 4;
  localparam int OUT2_CODE_LSB   = 2;
  localparam int OUT3_CODE_LSB   = 0;
  localparam int BRIGHT_CODE_LSB = 1;

  localparam logic [5:0] CTRL_RESET    = 6'h08;
  localparam logic [6:0] BRIGHT_RESET  = 7'h00;
  localparam logic [5:0] CURRENT_RESET = 6'h00;
  localparam logic [4:0] GPIO_RESET    = 5'h00;
  localparam logic [2:0] EXTSEL_RESET  = 3'h0;

  localparam int CLK_HZ            = 10_000_000;
  localparam int PWM_FREQ_HZ       = 20_000;
  localparam int PWM_PERIOD_CYCLES = CLK_HZ / PWM_FREQ_HZ;

  typedef struct packed {
    logic keypad_enable;
    logic internal_pwm_select;
    logic output_mode_select;
    logic out3_on;
    logic out2_on;
    logic out1_on;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] balance;
    logic [2:0] brightness;
    logic       overlap;
  } bright_type;

endpackage

//--- logic/keypad_pwm.sv
// Internal keypad PWM generator with logarithmic brightness.
module keypad_pwm
  import keypad_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] bright_i,
  output logic            pwm_o
);

  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic       next_pwm;

  // Returns the on-time in cycles; zero at code 0, and each step from code 1 up doubles the duty.
  function automatic logic [8:0] duty_cycles(input logic [2:0] code);
    logic [8:0] full;
    full = 9'(PWM_PERIOD_CYCLES);
    if (code == 3'h0) begin
      return 9'h000;
    end
    return full >> (3'h7 - code);
  endfunction

  always_comb begin
    next_cnt = (cnt == 9'(PWM_PERIOD_CYCLES - 1)) ? 9'h000 : cnt + 9'h001;
    next_pwm = next_cnt < duty_cycles(bright_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= 9'h000;
      pwm_o <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      pwm_o <= next_pwm;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pwm_wrap;
    cnt == 9'(PWM_PERIOD_CYCLES - 1) |=> cnt == 9'h000;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("PWM period wrong.");

  property p_pwm_off_code;
    bright_i == 3'h0 |=> !pwm_o;
  endproperty
  a_pwm_off_code: assert property (p_pwm_off_code) else $error("PWM on at code zero.");

  property p_pwm_full_code;
    bright_i == 3'h7 |=> pwm_o;
  endproperty
  a_pwm_full_code: assert property (p_pwm_full_code) else $error("PWM off at full code.");

  property p_pwm_min_duty;
    bright_i == 3'h1 && cnt == 9'h006 |=> !pwm_o;
  endproperty
  a_pwm_min_duty: assert property (p_pwm_min_duty) else $error("Duty at code one too long.");

endmodule
